//--- verilog/srw_pkg.sv
// Functional notes
// [RL1] With auto crossover on and a reversed cable seen, or reversal forced, swap the pair roles.
// [RL2] The data pin serves as eeprom data, general output 3, or a tx enable or tx clock monitor.
// [RL3] The clock pin serves as eeprom clock, general output 4, or an rx valid or rx clock monitor.
// [RL4] Whenever either pin is not in eeprom use, the eeprom select stays inactive.
// [RL5] General outputs 3 and 4 never act as inputs.
// [RL6] A low external reset returns all logic and registers to reset state; auto_crossover and link_default keep their values until re-latched at release.
// [RL7] A floating external reset reads high and the internal power-on reset takes over.
// [RL8] Host writes are ignored after power-up, reset or wake until one host read completes.
// [RL9] When enabled, a wake event in sleep drives the wake output with programmable polarity and drive; open drain only pulls low.
// [RL10] Only a host write with select and write strobe low wakes the device, whatever the data.
// [RL11] The host aims its waking write at the byte-order test register only.
// [RL12] The crossover strap high enables auto crossover; low or open disables it.
// [RL13] The speed strap is sampled when reset releases and kept as the link default.
// [RL14] Speed strap 0 gives 10 Mbps half duplex no autoneg; 1 gives 100 Mbps half duplex autoneg.
// [RL15] The board supplies a 25 MHz reference clock from a crystal or an oscillator.
package srw_pkg;
    localparam int unsigned CLK_HZ        = 50000000;
    localparam int unsigned POR_TIME_NS   = 1000;
    localparam int unsigned POR_CYCLES    = (POR_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam logic [1:0]  PIN_EEPROM    = 2'h0;
    localparam logic [1:0]  PIN_GPO       = 2'h1;
    localparam logic [1:0]  PIN_MON_A     = 2'h2;
    localparam logic [1:0]  PIN_MON_B     = 2'h3;

    typedef struct packed {
        logic speed_100;
        logic full_duplex;
        logic autoneg_on;
    } srw_link_t;

    localparam srw_link_t LINK_10_DEFAULT  = '{speed_100: 1'b0, full_duplex: 1'b0,
                                                autoneg_on: 1'b0};
    localparam srw_link_t LINK_100_DEFAULT = '{speed_100: 1'b1, full_duplex: 1'b0,
                                                autoneg_on: 1'b1};

    typedef enum logic [2:0] {
        ST_LOCKED = 3'b001,
        ST_ACTIVE = 3'b010,
        ST_SLEEP  = 3'b100
    } srw_state_t;
endpackage

//--- verilog/srw_sys_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module srw_sys_ctrl
    import srw_pkg::*;
#(
    parameter int unsigned POR_LEN = POR_CYCLES
)(
    input  wire logic       clk_sys,               // 50 MHz system clock
    input  wire logic       rst_b,                 // synchronous reset, active low
    input  wire logic       external_reset_n,      // reset pin, pulled high
    input  wire logic       por_n,                 // internal power-on reset, low at power-up
    input  wire logic       crossover_auto_strap,  // strap pin, pulled low
    input  wire logic       speed_strap,           // speed strap pin
    input  wire logic       reverse_detected,      // phy saw a reversed cable
    input  wire logic       reverse_manual,        // software forces reversal
    input  wire logic       host_select_n,         // host chip select pin
    input  wire logic       host_write_n,          // host write strobe pin
    input  wire logic       host_read_n,           // host read strobe pin
    input  wire logic       sleep_req,             // enter power-saving state, pulse
    input  wire logic       wake_detect,           // wake event seen, pulse
    input  wire logic       wake_out_en,           // wake output enabled
    input  wire logic       wake_out_high,         // wake output active high
    input  wire logic       wake_out_push_pull,    // 1 push-pull, 0 open drain
    input  wire logic [1:0] data_pin_mode,         // data pin function
    input  wire logic [1:0] clk_pin_mode,          // clock pin function
    input  wire logic       general_output_3,      // value for gpo 3
    input  wire logic       general_output_4,      // value for gpo 4
    input  wire logic       mii_tx_en,             // internal mii tx enable
    input  wire logic       mii_tx_clk,            // internal mii tx clock, sampled
    input  wire logic       mii_rx_dv,             // internal mii rx valid
    input  wire logic       mii_rx_clk,            // internal mii rx clock, sampled
    input  wire logic       ee_data_out,           // eeprom engine data to drive
    input  wire logic       ee_data_oe,            // eeprom engine drives data
    input  wire logic       ee_clk,                // eeprom engine clock
    input  wire logic       ee_select,             // eeprom engine select
    output logic            eeprom_data_io_o,      // data pin output
    output logic            eeprom_data_io_oe,     // data pin output enable
    input  wire logic       eeprom_data_io_i,      // data pin input
    output logic            ee_data_in,            // synced data pin to eeprom engine
    output logic            eeprom_serial_clock,   // clock pin
    output logic            eeprom_select,         // eeprom chip select
    output logic            wake_event_out_o,      // wake pin output
    output logic            wake_event_out_oe,     // wake pin output enable
    output logic            sys_reset,             // internal reset, active high
    output logic            write_enable,          // host writes accepted
    output logic            host_write_take,       // accepted host write, pulse
    output logic            sleeping,              // in power-saving state
    output logic            auto_crossover,        // latched auto crossover enable
    output logic            pair_swap,             // tx and rx pairs swapped
    output var srw_link_t   link_default           // default link settings
);
    if (POR_LEN < 1)
    begin : g_bad_por_len
        $error("POR_LEN must be at least 1");
    end

    logic [1:0] s_rst, s_por, s_cs, s_wr, s_rd, s_xo, s_spd, s_dio, s_txc, s_rxc;
    logic       rd_prev, wr_prev, hold_rst, sys_rst_d;
    logic [31:0] por_cnt;
    srw_state_t state, next_state;

    always_ff @(posedge clk_sys)
    begin
        s_rst <= {s_rst[0], external_reset_n};
        s_por <= {s_por[0], por_n};
        s_cs  <= {s_cs[0], host_select_n};
        s_wr  <= {s_wr[0], host_write_n};
        s_rd  <= {s_rd[0], host_read_n};
        s_xo  <= {s_xo[0], crossover_auto_strap};
        s_spd <= {s_spd[0], speed_strap};
        s_dio <= {s_dio[0], eeprom_data_io_i};
        s_txc <= {s_txc[0], mii_tx_clk};
        s_rxc <= {s_rxc[0], mii_rx_clk};
    end

    // any reset source holds the block; floating pin reads high [RL6] [RL7]
    assign hold_rst = !rst_b || !s_rst[1] || !s_por[1];

    always_ff @(posedge clk_sys)
    begin
        if (hold_rst)
            por_cnt <= '0;
        else if (por_cnt < POR_LEN)
            por_cnt <= por_cnt + 32'h1;
    end
    assign sys_reset = (por_cnt < POR_LEN); // [RL6]

    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
            sys_rst_d <= 1'b1;
        else
            sys_rst_d <= sys_reset;
    end

    // straps caught on the release edge of reset [RL13] [RL12]
    always_ff @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            auto_crossover <= 1'b0;
            link_default   <= LINK_10_DEFAULT;
        end
        else if (sys_rst_d && !sys_reset)
        begin
            auto_crossover <= s_xo[1];                                            // [RL12]
            link_default   <= s_spd[1] ? LINK_100_DEFAULT : LINK_10_DEFAULT;      // [RL14]
        end
    end

    assign pair_swap = (auto_crossover && reverse_detected) || reverse_manual; // [RL1]

    // completed read is a rising read strobe under select
    always_ff @(posedge clk_sys)
    begin
        if (sys_reset)
        begin
            rd_prev <= 1'b1;
            wr_prev <= 1'b1;
        end
        else
        begin
            rd_prev <= s_rd[1] | s_cs[1];
            wr_prev <= s_wr[1] | s_cs[1];
        end
    end

    logic rd_done, wr_start;
    assign rd_done  = !rd_prev && (s_rd[1] | s_cs[1]);
    assign wr_start = wr_prev && !(s_wr[1] | s_cs[1]);

    always_comb
    begin
        next_state = state;
        case (state)
            ST_LOCKED: if (rd_done) next_state = ST_ACTIVE;            // [RL8]
            ST_ACTIVE: if (sleep_req) next_state = ST_SLEEP;
            ST_SLEEP:  if (wr_start) next_state = ST_LOCKED;           // [RL10] [RL8]
            default:   next_state = ST_LOCKED;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_reset)
            state <= ST_LOCKED;
        else
            state <= next_state;
    end

    assign write_enable    = (state == ST_ACTIVE);
    assign sleeping        = (state == ST_SLEEP);
    assign host_write_take = wr_start && write_enable; // [RL8]

    // wake indication, cleared by the waking write, never wakes on its own [RL9] [RL10]
    logic wake_flag;
    always_ff @(posedge clk_sys)
    begin
        if (sys_reset || !sleeping)
            wake_flag <= 1'b0;
        else if (wake_detect && wake_out_en)
            wake_flag <= 1'b1;
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_reset)
        begin
            wake_event_out_o  <= 1'b0;
            wake_event_out_oe <= 1'b0;
        end
        else if (wake_out_push_pull)
        begin
            wake_event_out_o  <= wake_flag ~^ wake_out_high; // [RL9]
            wake_event_out_oe <= 1'b1;
        end
        else
        begin
            wake_event_out_o  <= 1'b0;
            wake_event_out_oe <= wake_flag;                  // [RL9]
        end
    end

    // pin multiplexing; gpo modes only drive, never sample [RL5]
    always_ff @(posedge clk_sys)
    begin
        if (sys_reset)
        begin
            eeprom_data_io_o    <= 1'b0;
            eeprom_data_io_oe   <= 1'b0;
            eeprom_serial_clock <= 1'b0;
            eeprom_select       <= 1'b0;
            ee_data_in          <= 1'b0;
        end
        else
        begin
            case (data_pin_mode)                                                  // [RL2]
                PIN_EEPROM: eeprom_data_io_o <= ee_data_out;
                PIN_GPO:    eeprom_data_io_o <= general_output_3;
                PIN_MON_A:  eeprom_data_io_o <= mii_tx_en;
                default:    eeprom_data_io_o <= s_txc[1];
            endcase
            eeprom_data_io_oe <= (data_pin_mode != PIN_EEPROM) || ee_data_oe;     // [RL5]
            case (clk_pin_mode)                                                   // [RL3]
                PIN_EEPROM: eeprom_serial_clock <= ee_clk;
                PIN_GPO:    eeprom_serial_clock <= general_output_4;
                PIN_MON_A:  eeprom_serial_clock <= mii_rx_dv;
                default:    eeprom_serial_clock <= s_rxc[1];
            endcase
            eeprom_select <= ee_select && (data_pin_mode == PIN_EEPROM)
                             && (clk_pin_mode == PIN_EEPROM);                     // [RL4]
            ee_data_in    <= (data_pin_mode == PIN_EEPROM) ? s_dio[1] : 1'b0;
        end
    end

    property p_select_idle;
        @(posedge clk_sys) disable iff (sys_reset)
        (data_pin_mode != PIN_EEPROM || clk_pin_mode != PIN_EEPROM) |=> !eeprom_select;
    endproperty
    a_select_idle: assert property (p_select_idle) else $error("select active off eeprom"); // [RL4]

    property p_no_write_locked;
        @(posedge clk_sys) disable iff (sys_reset)
        (state != ST_ACTIVE) |-> !host_write_take;
    endproperty
    a_no_write_locked: assert property (p_no_write_locked) else $error("write while locked"); // [RL8]

    property p_read_unlocks;
        @(posedge clk_sys) disable iff (sys_reset)
        (state == ST_LOCKED && rd_done) |=> write_enable;
    endproperty
    a_read_unlocks: assert property (p_read_unlocks) else $error("read did not unlock"); // [RL8]

    property p_wake_only_write;
        @(posedge clk_sys) disable iff (sys_reset)
        (sleeping && !wr_start) |=> sleeping;
    endproperty
    a_wake_only_write: assert property (p_wake_only_write) else $error("left sleep without write"); // [RL10]

    property p_write_wakes;
        @(posedge clk_sys) disable iff (sys_reset)
        (sleeping && wr_start) |=> (state == ST_LOCKED);
    endproperty
    a_write_wakes: assert property (p_write_wakes) else $error("write did not wake"); // [RL10]

    property p_wake_out;
        @(posedge clk_sys) disable iff (sys_reset)
        (sleeping && wake_detect && wake_out_en && wake_out_push_pull)
            |=> ##1 (wake_event_out_o == wake_out_high) || !sleeping || !wake_out_push_pull;
    endproperty
    a_wake_out: assert property (p_wake_out) else $error("wake output not asserted"); // [RL9]

    property p_swap;
        @(posedge clk_sys) disable iff (sys_reset)
        reverse_manual |-> pair_swap;
    endproperty
    a_swap: assert property (p_swap) else $error("manual reversal ignored"); // [RL1]

    property p_general_output_3;
        @(posedge clk_sys) disable iff (sys_reset)
        (data_pin_mode == PIN_GPO) |=> eeprom_data_io_oe && eeprom_data_io_o == $past(general_output_3);
    endproperty
    a_general_output_3: assert property (p_general_output_3) else $error("general_output_3 not driven"); // [RL2]

    property p_general_output_4;
        @(posedge clk_sys) disable iff (sys_reset)
        (clk_pin_mode == PIN_GPO) |=> eeprom_serial_clock == $past(general_output_4);
    endproperty
    a_general_output_4: assert property (p_general_output_4) else $error("general_output_4 not driven"); // [RL3]
endmodule
`default_nettype wire

//--- tb/srw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module srw_host_model (
    input  wire logic clk_sys,        // system clock
    input  wire logic data_o,         // design drive on eeprom data pin
    input  wire logic data_oe,        // design enable on eeprom data pin
    output logic      data_i,         // resolved eeprom data pin level
    output logic      host_select_n,  // host chip select
    output logic      host_write_n,   // host write strobe
    output logic      host_read_n     // host read strobe
);
    logic ee_bit = 1'b1;

    // eeprom answers only while the design lets go of the pin
    assign data_i = data_oe ? data_o : ee_bit;

    initial
    begin
        host_select_n = 1'b1;
        host_write_n  = 1'b1;
        host_read_n   = 1'b1;
    end

    // one host cycle; a waking write is meant for the byte test register
    task automatic access(input logic rd);
        @(posedge clk_sys);
        #1;
        host_select_n = 1'b0;
        host_read_n   = ~rd;
        host_write_n  = rd;
        repeat (4) @(posedge clk_sys);
        #1;
        {host_select_n, host_read_n, host_write_n} = 3'h7;
        repeat (6) @(posedge clk_sys);
        #1;
    endtask
endmodule
`default_nettype wire

//--- tb/test_system_reset_wake_pin_control.sv
`timescale 1ns/1ps
`default_nettype none
module test_system_reset_wake_pin_control;
    import srw_pkg::*;
    logic clk_sys = 1'b0, rst_b = 1'b0, ext_n = 1'b1, por_n = 1'b0, xs = 1'b1, ss = 1'b1;
    logic rdet = 1'b0, rman = 1'b0, slp = 1'b0, wdet = 1'b0, wen = 1'b0, whi = 1'b1, wpp = 1'b1;
    logic g3 = 1'b1, g4 = 1'b0, txe = 1'b0, txc = 1'b1, rxv = 1'b1, rxc = 1'b0;
    logic eo = 1'b1, eoe = 1'b0, eck = 1'b1, esel = 1'b1;
    logic [3:0] dsel, csel;
    logic [1:0] dmode = 2'h0, cmode = 2'h0;
    logic cs_n, wr_n, rd_n, d_o, d_oe, d_i, d_in, sck, ecs, w_o, w_oe;
    logic sys_reset, write_enable, take, sleeping, auto_x, swap;
    srw_link_t link;
    int errors = 0, checks_done = 0, takes = 0, cyc = 0;

    srw_sys_ctrl #(.POR_LEN(4)) u_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .external_reset_n(ext_n), .por_n(por_n),
        .crossover_auto_strap(xs), .speed_strap(ss), .reverse_detected(rdet),
        .reverse_manual(rman), .host_select_n(cs_n), .host_write_n(wr_n), .host_read_n(rd_n),
        .sleep_req(slp), .wake_detect(wdet), .wake_out_en(wen), .wake_out_high(whi),
        .wake_out_push_pull(wpp), .data_pin_mode(dmode), .clk_pin_mode(cmode),
        .general_output_3(g3), .general_output_4(g4), .mii_tx_en(txe), .mii_tx_clk(txc),
        .mii_rx_dv(rxv), .mii_rx_clk(rxc), .ee_data_out(eo), .ee_data_oe(eoe), .ee_clk(eck),
        .ee_select(esel), .eeprom_data_io_o(d_o), .eeprom_data_io_oe(d_oe),
        .eeprom_data_io_i(d_i), .ee_data_in(d_in), .eeprom_serial_clock(sck),
        .eeprom_select(ecs), .wake_event_out_o(w_o), .wake_event_out_oe(w_oe),
        .sys_reset(sys_reset), .write_enable(write_enable), .host_write_take(take),
        .sleeping(sleeping), .auto_crossover(auto_x), .pair_swap(swap), .link_default(link));

    srw_host_model u_host (
        .clk_sys(clk_sys), .data_o(d_o), .data_oe(d_oe), .data_i(d_i),
        .host_select_n(cs_n), .host_write_n(wr_n), .host_read_n(rd_n));

    initial
        forever #10 clk_sys = ~clk_sys; // board clock

    always @(posedge clk_sys)
    begin
        cyc++;
        if (take === 1'b1)
            takes++;
        if (cyc == 20000)
        begin
            errors++;
            $display("ERROR at %0t: timeout", $time);
            print_verdict();
        end
    end

    task automatic chk(input logic [2:0] got, input logic [2:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic settle();
        for (int i = 0; i < 40 && sys_reset !== 1'b0; i++)
            @(posedge clk_sys);
        @(posedge clk_sys);
        #1;
    endtask

    task automatic do_reset(input logic x, input logic s);
        @(posedge clk_sys);
        #1;
        rst_b = 1'b0;
        xs = x;
        ss = s;
        repeat (20) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        settle();
        chk(sys_reset, 1'b0, "reset release");
        chk(link, s ? LINK_100_DEFAULT : LINK_10_DEFAULT, "link default");
        chk(auto_x, x, "auto crossover");
        for (int i = 0; i < 4; i++)
        begin
            {rman, rdet} = 2'(i);
            @(posedge clk_sys);
            #1;
            chk(swap, rman | (x & rdet), "pair swap");
        end
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys);
        #1;
        por_n = 1'b1;
        do_reset(1'b1, 1'b1);
        u_host.access(1'b0);
        chk(3'(takes), 3'h0, "write before read");
        u_host.access(1'b1);
        chk(write_enable, 1'b1, "unlock");
        u_host.access(1'b0);
        chk(3'(takes), 3'h1, "write after read");
        for (int m = 0; m < 5; m++)
        begin
            dmode = (m == 4) ? 2'h0 : 2'(m);
            cmode = (m == 4) ? 2'h1 : 2'(m);
            {g3, g4, txe, txc, rxv, rxc, eo, eck} = ~{g3, g4, txe, txc, rxv, rxc, eo, eck};
            eoe   = (m == 4);
            esel  = (m != 2);
            dsel  = {txc, txe, g3, eo};
            csel  = {rxc, rxv, g4, eck};
            repeat (6) @(posedge clk_sys);
            #1;
            chk({d_oe, d_o}, {m % 4 != 0 || eoe, dsel[dmode]}, "data pin");
            chk(sck, csel[cmode], "clock pin");
            chk(ecs, esel && m == 0, "eeprom select");
            chk(d_in, (m == 0 || m == 4) && (eoe ? eo : 1'b1), "data in");
        end
        for (int k = 0; k < 3; k++)
        begin
            wen = (k < 2);
            whi = (k == 0);
            wpp = (k == 0);
            @(posedge clk_sys);
            #1;
            slp = 1'b1;
            @(posedge clk_sys);
            #1;
            slp = 1'b0;
            repeat (3) @(posedge clk_sys);
            #1;
            chk({sleeping, write_enable}, 2'b10, "sleep");
            chk({w_oe, w_o}, {wpp, wpp & ~whi}, "wake idle");
            wdet = 1'b1;
            @(posedge clk_sys);
            #1;
            wdet = 1'b0;
            repeat (3) @(posedge clk_sys);
            #1;
            chk({w_oe, w_o}, wen ? {1'b1, whi} : {wpp, wpp & ~whi}, "wake out");
            chk(sleeping, 1'b1, "still asleep");
            takes = 0;
            u_host.access(1'b0);
            chk({sleeping, write_enable}, 2'b00, "woken and locked");
            chk(3'(takes), 3'h0, "wake write taken");
            chk({w_oe, w_o}, {wpp, wpp & ~whi}, "wake cleared");
            u_host.access(1'b1);
            chk(write_enable, 1'b1, "unlock after wake");
        end
        ext_n = 1'b0;
        xs = 1'b0;
        ss = 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        chk({sys_reset, write_enable, ecs}, 3'h4, "pin reset");
        ext_n = 1'b1;
        settle();
        chk({sys_reset, write_enable}, 2'b00, "pin reset release");
        chk(link, LINK_10_DEFAULT, "pin reset link default");
        chk(auto_x, 1'b0, "pin reset auto crossover");
        do_reset(1'b0, 1'b0);
        print_verdict();
    end
endmodule
`default_nettype wire
